// File: rtl/spi_irq_cfg.svh
// Summary of operation
// R1 - Five mask bits, 0 masks and 1 passes, all reset to one.
// R2 - Masked status is raw condition ANDed with mask, resets to zero.
// R3 - Raw status reports each source regardless of mask, resets to zero.
// R4 - Reading tx overflow clear returns its state in bit 0 and clears it.
// R5 - Reading rx overflow clear returns its state in bit 0 and clears it.
// R6 - Reading rx underflow clear returns its state in bit 0 and clears it.
// R7 - Combined clear reads any-active, read clears all clearable interrupts.
// R8 - Multi-master clear location reads zero with no side effects.
// R9 - DMA control holds tx enable bit 1, rx enable bit 0, reset zero.
// R10 - Tx DMA request while enabled and tx level at or below watermark.
// R11 - Rx DMA request while enabled and rx level at least watermark plus one.
// R12 - Read-only 32-bit peripheral ident fixed at configuration.
// R13 - Read-only 32-bit component version constant.
// R14 - Data read pops rx FIFO right-justified, write pushes tx FIFO.
// R15 - Tx pushes only while enabled; both FIFOs held reset while disabled.
// R16 - Thirty-six aliased data locations behave identically.
// R17 - Raw tx empty active while tx level at or below tx threshold.
// R18 - Raw rx full active while rx level at least rx threshold plus one.
// R19 - Combined interrupt output is OR of masked status bits.
// R20 - Reserved bits read default value, writes to them ignored.
`ifndef SPI_IRQ_CFG_SVH
`define SPI_IRQ_CFG_SVH
`define OFS_INTERRUPT_MASK     8'h2c
`define OFS_MASKED_STATUS      8'h30
`define OFS_RAW_STATUS         8'h34
`define OFS_TX_OVERFLOW_CLEAR  8'h38
`define OFS_RX_OVERFLOW_CLEAR  8'h3c
`define OFS_RX_UNDERFLOW_CLEAR 8'h40
`define OFS_MULTI_MASTER_CLEAR 8'h44
`define OFS_COMBINED_CLEAR     8'h48
`define OFS_DMA_CONTROL        8'h4c
`define OFS_DMA_TX_LEVEL       8'h50
`define OFS_DMA_RX_LEVEL       8'h54
`define OFS_PERIPHERAL_IDENT   8'h58
`define OFS_COMPONENT_VERSION  8'h5c
`define OFS_DATA_FIRST         8'h60
`define DATA_WINDOW_COUNT      8'h24
`define MASK_RESET             5'h1f
`define MASK_RESERVED_BIT      32'h00000020
`define BIT_TX_EMPTY           0
`define BIT_TX_OVERFLOW        1
`define BIT_RX_UNDERFLOW       2
`define BIT_RX_OVERFLOW        3
`define BIT_RX_FULL            4
`define BIT_TX_DMA_ENABLE      1
`define BIT_RX_DMA_ENABLE      0
// Arbitrary neutral values
`define PERIPHERAL_IDENT_VALUE 32'h00000000
`define COMPONENT_VERSION_VALUE 32'h00010000
`define FIFO_DEPTH             16
`define FIFO_LEVEL_BITS        5
`endif

// File: rtl/spi_irq_pkg.sv
package spi_irq_pkg;
  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic        tx_full;
    logic        tx_empty;
    logic        rx_empty;
    logic [4:0]  tx_level;
    logic [4:0]  rx_level;
  } fifo_state_t;
endpackage

// File: rtl/spi_irq_dma_data_regs.sv
`include "spi_irq_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sync_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int LW    = 5
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [LW-1:0]         level,
  output logic [LW-1:0]         level_next,
  output logic [WIDTH-1:0]      head_next
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [LW-2:0]    wr_ptr;
  logic [LW-2:0]    rd_ptr;
  logic [LW-2:0]    next_wr_ptr;
  logic [LW-2:0]    next_rd_ptr;
  logic [LW-1:0]    next_level;
  logic             push;
  logic             pop;

  assign in_ready  = (level != LW'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Lookahead lets the owner register what the FIFO shows next cycle
  assign level_next = next_level;
  // Forward a push into an empty head slot; zero when nothing will be held
  assign head_next  = (next_level == '0) ? '0
                    : ((push && (wr_ptr == next_rd_ptr)) ? in_data : mem[next_rd_ptr]);

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_level  = level + LW'(push) - LW'(pop);
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_level  = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level  <= next_level;
    end
  end

  // Storage needs no reset; contents are unreadable until pushed
  always_ff @(posedge clk) begin
    if (push && !flush) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

module spi_irq_dma_data_regs
  import spi_irq_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        NRST,
  input  wire logic        SEL,
  input  wire logic        WRITE,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  output logic [31:0]      RDATA,
  input  wire logic        CONTROLLER_ENABLE,
  input  wire logic [2:0]  TX_IRQ_THRESHOLD,
  input  wire logic [2:0]  RX_IRQ_THRESHOLD,
  output logic             TX_WORD_VALID,
  input  wire logic        TX_WORD_TAKE,
  output logic [15:0]      TX_WORD,
  input  wire logic        RX_WORD_VALID,
  output logic             RX_WORD_READY,
  input  wire logic [15:0] RX_WORD,
  output logic             SPI_IRQ,
  output logic             DMA_TX_REQ,
  output logic             DMA_RX_REQ
);
  reg_req_t    req;
  fifo_state_t fs;
  logic [4:0]  interrupt_mask;
  logic [4:0]  raw_interrupt_status;
  logic [1:0]  dma_control;
  logic [2:0]  tx_dma_watermark;
  logic [2:0]  rx_dma_watermark;
  logic [4:0]  next_interrupt_mask;
  logic [4:0]  next_raw;
  logic [1:0]  next_dma_control;
  logic [2:0]  next_tx_dma_watermark;
  logic [2:0]  next_rx_dma_watermark;
  logic [31:0] next_rdata;
  logic        next_irq;
  logic        next_tx_req;
  logic        next_rx_req;
  logic        sync_en_a;
  logic        sync_en;
  logic        flush;
  logic        is_data;
  logic        rd;
  logic        wr;
  logic        tx_push;
  logic        tx_ready;
  logic        rx_pop;
  logic        rx_valid;
  logic [15:0] rx_data;
  logic        tx_out_valid;
  logic        rx_in_ready;
  logic [4:0]  tx_level_next;
  logic [4:0]  rx_level_next;
  logic [15:0] tx_head_next;
  logic        next_tx_word_valid;
  logic        next_rx_word_ready;
  logic        wr_mask;
  logic        wr_dma_control;
  logic        wr_tx_watermark;
  logic        wr_rx_watermark;
  logic        clr_txo;
  logic        clr_rxo;
  logic        clr_rxu;
  logic        set_txo;
  logic        set_rxo;
  logic        set_rxu;
  logic        clear_any;
  logic [31:0] word_mask;
  logic [31:0] word_masked;
  logic [31:0] word_raw;
  logic [31:0] word_dma;
  logic [31:0] word_tx_watermark;
  logic [31:0] word_rx_watermark;

  assign req      = '{sel: SEL, write: WRITE, addr: ADDR, wdata: WDATA};
  assign rd       = req.sel && !req.write;
  assign wr       = req.sel && req.write;
  assign is_data  = (req.addr >= `OFS_DATA_FIRST)
                 && (req.addr < `OFS_DATA_FIRST + (`DATA_WINDOW_COUNT << 2))
                 && (req.addr[1:0] == 2'h0); // see R16
  // Enable pin is asynchronous to the bus clock
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      sync_en_a <= 1'b0;
      sync_en   <= 1'b0;
    end else begin
      sync_en_a <= CONTROLLER_ENABLE;
      sync_en   <= sync_en_a;
    end
  end
  assign flush   = !sync_en; // see R15
  assign tx_push = wr && is_data && sync_en; // see R14 see R15
  assign rx_pop  = rd && is_data && rx_valid; // see R14

  sync_fifo #(.WIDTH(16), .DEPTH(`FIFO_DEPTH), .LW(`FIFO_LEVEL_BITS)) tx_fifo (
    .clk       (SYS_CLK),
    .rst_n     (NRST),
    .flush     (flush),
    .in_valid  (tx_push),
    .in_ready  (tx_ready),
    .in_data   (req.wdata[15:0]),
    .out_valid (tx_out_valid),
    .out_ready (TX_WORD_TAKE),
    .out_data  (),
    .level     (fs.tx_level),
    .level_next (tx_level_next),
    .head_next (tx_head_next)
  );

  sync_fifo #(.WIDTH(16), .DEPTH(`FIFO_DEPTH), .LW(`FIFO_LEVEL_BITS)) rx_fifo (
    .clk       (SYS_CLK),
    .rst_n     (NRST),
    .flush     (flush),
    .in_valid  (RX_WORD_VALID),
    .in_ready  (rx_in_ready),
    .in_data   (RX_WORD),
    .out_valid (rx_valid),
    .out_ready (rx_pop),
    .out_data  (rx_data),
    .level     (fs.rx_level),
    .level_next (rx_level_next),
    .head_next ()
  );

  assign fs.tx_full  = !tx_ready;
  assign fs.tx_empty = !tx_out_valid;
  assign fs.rx_empty = !rx_valid;

  // Write strobes per register; other offsets outside the data window ignore writes
  assign wr_mask         = wr && (req.addr == `OFS_INTERRUPT_MASK); // see R20
  assign wr_dma_control  = wr && (req.addr == `OFS_DMA_CONTROL);
  assign wr_tx_watermark = wr && (req.addr == `OFS_DMA_TX_LEVEL);
  assign wr_rx_watermark = wr && (req.addr == `OFS_DMA_RX_LEVEL);

  // Clear and set events kept apart so the set can win below
  assign clr_txo = rd && (req.addr == `OFS_TX_OVERFLOW_CLEAR || req.addr == `OFS_COMBINED_CLEAR); // see R4 see R7
  assign clr_rxo = rd && (req.addr == `OFS_RX_OVERFLOW_CLEAR || req.addr == `OFS_COMBINED_CLEAR); // see R5 see R7
  assign clr_rxu = rd && (req.addr == `OFS_RX_UNDERFLOW_CLEAR || req.addr == `OFS_COMBINED_CLEAR); // see R6 see R7
  assign set_txo = wr && is_data && sync_en && !tx_ready;
  assign set_rxo = RX_WORD_VALID && !rx_in_ready && sync_en;
  assign set_rxu = rd && is_data && !rx_valid;

  // Read words, reserved bits at their defaults
  assign word_mask         = `MASK_RESERVED_BIT | {27'h0, interrupt_mask}; // see R20
  assign word_masked       = {27'h0, raw_interrupt_status & interrupt_mask}; // see R2
  assign word_raw          = {27'h0, raw_interrupt_status}; // see R3
  assign word_dma          = {30'h0, dma_control}; // see R9
  assign word_tx_watermark = {29'h0, tx_dma_watermark};
  assign word_rx_watermark = {29'h0, rx_dma_watermark};
  assign clear_any         = |(raw_interrupt_status[3:1] & interrupt_mask[3:1]); // see R7

  always_comb begin
    next_interrupt_mask   = interrupt_mask;
    next_dma_control      = dma_control;
    next_tx_dma_watermark = tx_dma_watermark;
    next_rx_dma_watermark = rx_dma_watermark;
    if (wr_mask) begin
      next_interrupt_mask = req.wdata[4:0]; // see R1 see R20
    end
    if (wr_dma_control) begin
      next_dma_control = req.wdata[1:0]; // see R9
    end
    if (wr_tx_watermark) begin
      next_tx_dma_watermark = req.wdata[2:0];
    end
    if (wr_rx_watermark) begin
      next_rx_dma_watermark = req.wdata[2:0];
    end
  end

  // Sticky event bits: a new event in the clearing cycle survives the clear
  always_comb begin
    next_raw = raw_interrupt_status;
    next_raw[`BIT_TX_EMPTY] = (fs.tx_level <= {2'b00, TX_IRQ_THRESHOLD}); // see R17
    next_raw[`BIT_RX_FULL]  = (fs.rx_level >= {2'b00, RX_IRQ_THRESHOLD} + 5'h1); // see R18
    if (clr_txo) begin
      next_raw[`BIT_TX_OVERFLOW] = 1'b0; // see R4 see R7
    end
    if (clr_rxo) begin
      next_raw[`BIT_RX_OVERFLOW] = 1'b0; // see R5 see R7
    end
    if (clr_rxu) begin
      next_raw[`BIT_RX_UNDERFLOW] = 1'b0; // see R6 see R7
    end
    if (set_txo) begin
      next_raw[`BIT_TX_OVERFLOW] = 1'b1;
    end
    if (set_rxo) begin
      next_raw[`BIT_RX_OVERFLOW] = 1'b1;
    end
    if (set_rxu) begin
      next_raw[`BIT_RX_UNDERFLOW] = 1'b1;
    end
    if (flush) begin
      next_raw[`BIT_TX_OVERFLOW]  = 1'b0;
      next_raw[`BIT_RX_OVERFLOW]  = 1'b0;
      next_raw[`BIT_RX_UNDERFLOW] = 1'b0;
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    if (rd) begin
      if (is_data) begin
        next_rdata = {16'h0000, rx_valid ? rx_data : 16'h0000}; // see R14 see R16
      end else begin
        unique case (req.addr)
          `OFS_INTERRUPT_MASK:     next_rdata = word_mask; // see R20
          `OFS_MASKED_STATUS:      next_rdata = word_masked; // see R2
          `OFS_RAW_STATUS:         next_rdata = word_raw; // see R3
          `OFS_TX_OVERFLOW_CLEAR:  next_rdata = {31'h0, raw_interrupt_status[`BIT_TX_OVERFLOW]}; // see R4
          `OFS_RX_OVERFLOW_CLEAR:  next_rdata = {31'h0, raw_interrupt_status[`BIT_RX_OVERFLOW]}; // see R5
          `OFS_RX_UNDERFLOW_CLEAR: next_rdata = {31'h0, raw_interrupt_status[`BIT_RX_UNDERFLOW]}; // see R6
          `OFS_MULTI_MASTER_CLEAR: next_rdata = 32'h00000000; // see R8
          `OFS_COMBINED_CLEAR:     next_rdata = {31'h0, clear_any}; // see R7
          `OFS_DMA_CONTROL:        next_rdata = word_dma;
          `OFS_DMA_TX_LEVEL:       next_rdata = word_tx_watermark;
          `OFS_DMA_RX_LEVEL:       next_rdata = word_rx_watermark;
          `OFS_PERIPHERAL_IDENT:   next_rdata = `PERIPHERAL_IDENT_VALUE; // see R12
          `OFS_COMPONENT_VERSION:  next_rdata = `COMPONENT_VERSION_VALUE; // see R13
          default:                 next_rdata = 32'h00000000;
        endcase
      end
    end
  end

  // Requests follow the current level; one-cycle lag is acceptable to the DMA engine
  always_comb begin
    next_irq    = |(next_raw & next_interrupt_mask); // see R19
    next_tx_req = next_dma_control[`BIT_TX_DMA_ENABLE]
               && (fs.tx_level <= {2'b00, next_tx_dma_watermark}); // see R10
    next_rx_req = next_dma_control[`BIT_RX_DMA_ENABLE]
               && (fs.rx_level >= {2'b00, next_rx_dma_watermark} + 5'h1); // see R11
  end

  // Pins follow the FIFO lookahead, so they match the FIFO state cycle for cycle
  always_comb begin
    next_tx_word_valid = (tx_level_next != 5'h00);
    next_rx_word_ready = (rx_level_next != 5'(`FIFO_DEPTH));
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      interrupt_mask   <= `MASK_RESET; // see R1
      dma_control      <= 2'h0; // see R9
      tx_dma_watermark <= 3'h0;
      rx_dma_watermark <= 3'h0;
    end else begin
      interrupt_mask   <= next_interrupt_mask;
      dma_control      <= next_dma_control;
      tx_dma_watermark <= next_tx_dma_watermark;
      rx_dma_watermark <= next_rx_dma_watermark;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      raw_interrupt_status <= 5'h00; // see R3
    end else begin
      raw_interrupt_status <= next_raw;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= 32'h00000000;
    end else begin
      RDATA <= next_rdata;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      SPI_IRQ    <= 1'b0;
      DMA_TX_REQ <= 1'b0;
      DMA_RX_REQ <= 1'b0;
    end else begin
      SPI_IRQ    <= next_irq;
      DMA_TX_REQ <= next_tx_req;
      DMA_RX_REQ <= next_rx_req;
    end
  end

  // Ready stays high in reset; a flushed rx FIFO always has room
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      TX_WORD_VALID <= 1'b0;
      TX_WORD       <= 16'h0000;
      RX_WORD_READY <= 1'b1;
    end else begin
      TX_WORD_VALID <= next_tx_word_valid;
      TX_WORD       <= tx_head_next; // see R14
      RX_WORD_READY <= next_rx_word_ready;
    end
  end
endmodule

`default_nettype wire

// File: dv/spi_irq_dma_data_regs_assertions.sv
`include "spi_irq_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module spi_regs_checker (
  input wire logic        SYS_CLK,
  input wire logic        NRST,
  input wire logic        SEL,
  input wire logic        WRITE,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] RDATA,
  input wire logic        SPI_IRQ
);
  logic rd;
  assign rd = SEL && !WRITE;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  chk_idle_read_zero: assert property (!$past(rd) |-> RDATA == 32'h0)
    else $error("read data not zero");
  chk_ident_value: assert property (rd && ADDR == `OFS_PERIPHERAL_IDENT |=> RDATA == `PERIPHERAL_IDENT_VALUE)
    else $error("ident wrong");
  chk_version_value: assert property (rd && ADDR == `OFS_COMPONENT_VERSION |=> RDATA == `COMPONENT_VERSION_VALUE)
    else $error("version wrong");
  chk_mst_reads_zero: assert property (rd && ADDR == `OFS_MULTI_MASTER_CLEAR |=> RDATA == 32'h0)
    else $error("reserved clear not zero");
  chk_mask_upper_bits: assert property (rd && ADDR == `OFS_INTERRUPT_MASK |=> RDATA[31:5] == 27'h1)
    else $error("mask upper bits wrong");
  chk_dma_upper_bits: assert property (rd && ADDR == `OFS_DMA_CONTROL |=> RDATA[31:2] == 30'h0)
    else $error("dma control upper bits");
  chk_clear_upper_bits: assert property (rd && ADDR inside {`OFS_TX_OVERFLOW_CLEAR, `OFS_RX_OVERFLOW_CLEAR,
    `OFS_RX_UNDERFLOW_CLEAR, `OFS_COMBINED_CLEAR} |=> RDATA[31:1] == 31'h0) else $error("clear upper bits");
  chk_data_upper_bits: assert property (rd && ADDR >= `OFS_DATA_FIRST && ADDR <= 8'hec |=> RDATA[31:16] == 16'h0)
    else $error("data upper bits");
  chk_txo_read_clears: assert property (rd && ADDR == 8'h38 ##1 rd && ADDR == 8'h38 |=> !RDATA[0])
    else $error("tx overflow not cleared");
  cover property (rd && ADDR == `OFS_TX_OVERFLOW_CLEAR ##1 RDATA[0]);
  cover property (rd && ADDR == `OFS_COMBINED_CLEAR ##1 RDATA[0]);
  cover property ($fell(SPI_IRQ));
endmodule
bind spi_irq_dma_data_regs spi_regs_checker chk (.SYS_CLK(SYS_CLK), .NRST(NRST), .SEL(SEL), .WRITE(WRITE),
  .ADDR(ADDR), .RDATA(RDATA), .SPI_IRQ(SPI_IRQ));
`default_nettype wire

// File: dv/spi_shifter_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_shifter_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        push_req,
  input  wire logic [15:0] push_data,
  input  wire logic        take_en,
  input  wire logic        word_valid,
  input  wire logic [15:0] word,
  output logic             word_take,
  output logic             push_valid,
  output logic [15:0]      push_word,
  output logic [15:0]      popped
);
  // A shifter cannot stall, so pushes ignore ready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_take <= 1'b0;
      push_valid <= 1'b0;
      push_word <= 16'h0;
      popped <= 16'h0;
    end else begin
      word_take <= take_en;
      push_valid <= push_req;
      push_word <= push_req ? push_data : ~push_word;
      if (word_take && word_valid) begin
        popped <= word;
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/spi_irq_dma_data_regs_tb_top.sv
`include "spi_irq_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("unexpected %s %h %h", n, e, g); end end
module spi_irq_dma_data_regs_tb_top import spi_irq_pkg::*;;
  typedef struct packed { logic w; logic [7:0] a; logic [31:0] d; } row_t;
  logic        clk = 1'b0, nrst = 1'b0, sel = 1'b0, wr = 1'b0, en = 1'b0, push = 1'b0, take_en = 1'b0;
  logic [7:0]  addr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, r;
  logic        tx_v, take, rx_v, rx_rdy, irq, dtx, drx;
  logic [15:0] tx_w, rx_w, popped, push_d = 16'h0;
  int          error_cnt = 0, checked = 0;
  row_t rows [18] = '{'{1'b0, 8'h2c, 32'h3f}, '{1'b0, 8'h30, 32'h1}, '{1'b0, 8'h34, 32'h1},
    '{1'b0, 8'h4c, 32'h0}, '{1'b0, 8'h54, 32'h0}, '{1'b0, 8'h44, 32'h0}, '{1'b0, 8'h10, 32'h0},
    '{1'b0, 8'h58, `PERIPHERAL_IDENT_VALUE}, '{1'b0, 8'h5c, `COMPONENT_VERSION_VALUE},
    '{1'b1, 8'h4c, 32'hffffffff}, '{1'b0, 8'h4c, 32'h3}, '{1'b1, 8'h50, 32'hfffffffd},
    '{1'b0, 8'h50, 32'h5}, '{1'b1, 8'h58, 32'hffffffff}, '{1'b0, 8'h58, `PERIPHERAL_IDENT_VALUE},
    '{1'b1, 8'h2c, 32'h0}, '{1'b0, 8'h2c, 32'h20}, '{1'b0, 8'h30, 32'h0}};
  always #2 clk = ~clk;
  spi_irq_dma_data_regs uut (.SYS_CLK(clk), .NRST(nrst), .SEL(sel), .WRITE(wr), .ADDR(addr), .WDATA(wdata),
    .RDATA(rdata), .CONTROLLER_ENABLE(en), .TX_IRQ_THRESHOLD(3'h0), .RX_IRQ_THRESHOLD(3'h2),
    .TX_WORD_VALID(tx_v), .TX_WORD_TAKE(take), .TX_WORD(tx_w), .RX_WORD_VALID(rx_v),
    .RX_WORD_READY(rx_rdy), .RX_WORD(rx_w), .SPI_IRQ(irq), .DMA_TX_REQ(dtx), .DMA_RX_REQ(drx));
  spi_shifter_model far (.clk(clk), .rst_n(nrst), .push_req(push), .push_data(push_d), .take_en(take_en),
    .word_valid(tx_v), .word(tx_w), .word_take(take), .push_valid(rx_v), .push_word(rx_w), .popped(popped));
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    sel <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    sel <= 1'b0;
    #1 r = rdata;
  endtask
  task automatic rx_push(input logic [15:0] d);
    @(posedge clk);
    push <= 1'b1;
    push_d <= d;
    @(posedge clk);
    push <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    #1 `CK("irq", 1'b1, irq)
    foreach (rows[i]) begin
      acc(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) `CK($sformatf("reg %h", rows[i].a), rows[i].d, r)
    end
    `CK("irq", 1'b0, irq)
    `CK("tx dma", 1'b1, dtx)
    `CK("rx dma", 1'b0, drx)
    acc(1'b1, 8'h2c, 32'h1f);
    acc(1'b1, 8'h60, 32'h1234);
    `CK("tx idle", 1'b0, tx_v)
    @(posedge clk);
    en <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 17; i++) acc(1'b1, 8'hec - 8'(4 * i), {16'hffff, 16'ha500 + 16'(i)});
    repeat (2) @(posedge clk);
    #1 `CK("tx head", 16'ha500, tx_w)
    `CK("tx dma", 1'b0, dtx)
    acc(1'b0, 8'h34, 32'h0);
    `CK("raw", 32'h2, r)
    @(posedge clk);
    sel <= 1'b1;
    wr <= 1'b0;
    addr <= 8'h38;
    @(posedge clk);
    #1 `CK("txo", 32'h1, rdata)
    @(posedge clk);
    sel <= 1'b0;
    take_en <= 1'b1;
    #1 `CK("txo again", 32'h0, rdata)
    repeat (24) @(posedge clk);
    take_en <= 1'b0;
    #1 `CK("tx last", 16'ha50f, popped)
    `CK("tx dma", 1'b1, dtx)
    acc(1'b1, 8'h54, 32'h1);
    rx_push(16'hbeef);
    repeat (2) @(posedge clk);
    #1 `CK("rx dma", 1'b0, drx)
    rx_push(16'h1000);
    rx_push(16'h1001);
    repeat (2) @(posedge clk);
    #1 `CK("rx dma", 1'b1, drx)
    acc(1'b0, 8'h34, 32'h0);
    `CK("raw", 32'h11, r)
    acc(1'b0, 8'h7c, 32'h0);
    `CK("rx word", 32'hbeef, r)
    repeat (3) acc(1'b0, 8'h60, 32'h0);
    `CK("rx empty", 32'h0, r)
    acc(1'b0, 8'h40, 32'h0);
    `CK("rxu", 32'h1, r)
    for (int i = 0; i < 17; i++) rx_push(16'(i));
    acc(1'b0, 8'h3c, 32'h0);
    `CK("rxo", 32'h1, r)
    rx_push(16'h0);
    acc(1'b0, 8'h48, 32'h0);
    `CK("all", 32'h1, r)
    acc(1'b0, 8'h3c, 32'h0);
    `CK("rxo after", 32'h0, r)
    @(posedge clk);
    en <= 1'b0;
    repeat (4) @(posedge clk);
    #1 `CK("flushed", 1'b1, rx_rdy)
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    acc(1'b0, 8'h2c, 32'h0);
    `CK("mask", 32'h3f, r)
    wrap_up;
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    wrap_up;
  end
endmodule
`default_nettype wire
